// *** hdl/serial_rx.sv ***
`timescale 1ns/1ps
module serial_rx
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_input_pin,
    output logic receive_irq
);
    typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_t;

    logic [7:0] rx_status_reg;
    logic [7:0] rx_data_reg;
    logic [7:0] tx_status_reg;
    logic [7:0] baud_ctrl_reg;
    logic [7:0] div_high_reg;
    logic [7:0] div_low_reg;
    logic [7:0] irq_ctrl_reg;
    logic cpl_flag_reg;
    logic wake_seen_reg;
    logic line_prev_reg;
    rx_state_t state_reg;
    logic [15:0] baud_cnt_reg;
    logic [3:0] os_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic [8:0] shift_reg;
    logic [15:0] tick_div;
    logic tick;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic rd_fire;
    logic rd_data_fire;
    logic rx_enabled;
    logic accept_frame;
    rx_pkg::frame_t frame_in;
    logic frame_done;
    logic fall_edge;
    logic rise_edge;
    logic cont_clear;

    function automatic logic [7:0] wmerge(input logic [7:0] old,
        input logic [7:0] mask, input logic [31:0] wd, input logic lane);
        wmerge = lane ? ((old & ~mask) | (wd[7:0] & mask)) : old;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // bus slave: address and data taken in either order
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_data_fire = rd_fire
        && hit(s_axi_araddr, rx_pkg::ADDR_RX_DATA);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rx_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_reg)
                    rx_pkg::ADDR_RX_STATUS, rx_pkg::ADDR_RX_DATA,
                    rx_pkg::ADDR_TX_STATUS, rx_pkg::ADDR_BAUD_CTRL,
                    rx_pkg::ADDR_DIV_HIGH, rx_pkg::ADDR_DIV_LOW,
                    rx_pkg::ADDR_IRQ_CTRL:
                        s_axi_bresp <= rx_pkg::RESP_OKAY;
                    default:
                        s_axi_bresp <= rx_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= rx_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rx_pkg::RESP_OKAY;
            case (s_axi_araddr)
                rx_pkg::ADDR_RX_STATUS:
                    s_axi_rdata <= {24'h000000, rx_status_reg};
                rx_pkg::ADDR_RX_DATA:
                    s_axi_rdata <= {24'h000000, rx_data_reg};
                rx_pkg::ADDR_TX_STATUS:
                    s_axi_rdata <= {24'h000000, tx_status_reg};
                rx_pkg::ADDR_BAUD_CTRL:
                    s_axi_rdata <= {24'h000000, baud_ctrl_reg[7],
                        state_reg == ST_IDLE, baud_ctrl_reg[5:0]};
                rx_pkg::ADDR_DIV_HIGH:
                    s_axi_rdata <= {24'h000000, div_high_reg};
                rx_pkg::ADDR_DIV_LOW:
                    s_axi_rdata <= {24'h000000, div_low_reg};
                rx_pkg::ADDR_IRQ_CTRL:
                    s_axi_rdata <= {24'h000000, irq_ctrl_reg[7:1],
                        cpl_flag_reg};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= rx_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // writable control registers
    assign cont_clear = wr_fire && w_strb_reg[0]
        && hit(aw_addr_reg, rx_pkg::ADDR_RX_STATUS)
        && !w_data_reg[rx_pkg::BIT_CONT_EN];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_status_reg <= rx_pkg::RST_REG8;
            div_high_reg <= rx_pkg::RST_REG8;
            div_low_reg <= rx_pkg::RST_REG8;
            irq_ctrl_reg <= rx_pkg::RST_REG8;
        end
        else if (wr_fire)
        begin
            if (hit(aw_addr_reg, rx_pkg::ADDR_TX_STATUS))
                tx_status_reg <= wmerge(tx_status_reg,
                    rx_pkg::TX_STATUS_WMASK, w_data_reg, w_strb_reg[0]);
            if (hit(aw_addr_reg, rx_pkg::ADDR_DIV_HIGH))
                div_high_reg <= wmerge(div_high_reg, 8'hFF,
                    w_data_reg, w_strb_reg[0]);
            if (hit(aw_addr_reg, rx_pkg::ADDR_DIV_LOW))
                div_low_reg <= wmerge(div_low_reg, 8'hFF,
                    w_data_reg, w_strb_reg[0]);
            if (hit(aw_addr_reg, rx_pkg::ADDR_IRQ_CTRL))
                irq_ctrl_reg <= wmerge(irq_ctrl_reg,
                    rx_pkg::IRQ_CTRL_WMASK, w_data_reg, w_strb_reg[0]);
        end
    end

    // receive path enables
    assign rx_enabled = rx_status_reg[rx_pkg::BIT_SPORT_EN]
        && !tx_status_reg[rx_pkg::BIT_CLOCKED_MODE]
        && !irq_ctrl_reg[rx_pkg::BIT_SLEEP]
        && !baud_ctrl_reg[rx_pkg::BIT_WAKE_EN];

    // divisor gives one tick per sixteenth of a bit; prescale bits ignored
    assign tick_div = baud_ctrl_reg[rx_pkg::BIT_WIDE_DIV]
        ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};
    assign tick = (baud_cnt_reg == tick_div);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !rx_enabled)
            baud_cnt_reg <= 16'h0000;
        else if (tick)
            baud_cnt_reg <= 16'h0000;
        else
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
    end

    // oversampled frame recovery
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !rx_enabled)
        begin
            state_reg <= ST_IDLE;
            os_cnt_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 9'h000;
        end
        else if (tick)
        begin
            os_cnt_reg <= os_cnt_reg + 4'h1;
            case (state_reg)
                ST_IDLE:
                begin
                    os_cnt_reg <= 4'h0;
                    // overrun halts reception
                    if (!serial_input_pin
                        && rx_status_reg[rx_pkg::BIT_CONT_EN]
                        && !rx_status_reg[rx_pkg::BIT_OVERRUN])
                        state_reg <= ST_START;
                end
                ST_START:
                    if (os_cnt_reg == rx_pkg::OVERSAMPLE_MID)
                    begin
                        os_cnt_reg <= 4'h0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= serial_input_pin ? ST_IDLE : ST_DATA;
                    end
                ST_DATA:
                    if (os_cnt_reg == rx_pkg::OVERSAMPLE_LAST)
                    begin
                        shift_reg <= {serial_input_pin, shift_reg[8:1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == (rx_status_reg[rx_pkg::BIT_NINTH_EN]
                            ? 4'h8 : 4'h7))
                            state_reg <= ST_STOP;
                    end
                ST_STOP:
                    if (os_cnt_reg == rx_pkg::OVERSAMPLE_LAST)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign frame_done = tick && state_reg == ST_STOP
        && os_cnt_reg == rx_pkg::OVERSAMPLE_LAST;
    // eight-bit frames leave data one place high in the shifter
    assign frame_in.data = rx_status_reg[rx_pkg::BIT_NINTH_EN]
        ? shift_reg[7:0] : shift_reg[8:1];
    assign frame_in.ninth = rx_status_reg[rx_pkg::BIT_NINTH_EN] & shift_reg[8];
    assign frame_in.frame_err = !serial_input_pin;
    assign accept_frame = frame_done
        && !(rx_status_reg[rx_pkg::BIT_NINTH_EN]
        && rx_status_reg[rx_pkg::BIT_ADDR_DET] && !frame_in.ninth);

    // status, data and error flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_status_reg <= rx_pkg::RST_REG8;
            rx_data_reg <= rx_pkg::RST_REG8;
        end
        else
        begin
            if (wr_fire && hit(aw_addr_reg, rx_pkg::ADDR_RX_STATUS))
                rx_status_reg <= wmerge(rx_status_reg,
                    rx_pkg::RX_STATUS_WMASK, w_data_reg, w_strb_reg[0]);
            if (cont_clear)
                rx_status_reg[rx_pkg::BIT_OVERRUN] <= 1'b0;
            if (accept_frame && cpl_flag_reg)
                rx_status_reg[rx_pkg::BIT_OVERRUN] <= 1'b1;
            else if (accept_frame)
            begin
                rx_data_reg <= frame_in.data;
                rx_status_reg[rx_pkg::BIT_NINTH_RX] <= frame_in.ninth;
                rx_status_reg[rx_pkg::BIT_FRAME_ERR] <= frame_in.frame_err;
            end
        end
    end

    // complete flag: set wins over the read that clears it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cpl_flag_reg <= 1'b0;
        else if ((accept_frame && !cpl_flag_reg)
            || (baud_ctrl_reg[rx_pkg::BIT_WAKE_EN] && !wake_seen_reg
            && fall_edge))
            cpl_flag_reg <= 1'b1;
        else if (rd_data_fire)
            cpl_flag_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            receive_irq <= 1'b0;
        else
            receive_irq <= cpl_flag_reg
                && irq_ctrl_reg[rx_pkg::BIT_IRQ_EN];
    end

    // wake-up watch runs even in sleep
    assign fall_edge = line_prev_reg && !serial_input_pin;
    assign rise_edge = !line_prev_reg && serial_input_pin;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_prev_reg <= 1'b1;
            wake_seen_reg <= 1'b0;
            baud_ctrl_reg <= rx_pkg::RST_REG8;
        end
        else
        begin
            line_prev_reg <= serial_input_pin;
            if (wr_fire && hit(aw_addr_reg, rx_pkg::ADDR_BAUD_CTRL))
            begin
                baud_ctrl_reg <= wmerge(baud_ctrl_reg,
                    rx_pkg::BAUD_CTRL_WMASK, w_data_reg, w_strb_reg[0]);
                wake_seen_reg <= 1'b0;
            end
            if (baud_ctrl_reg[rx_pkg::BIT_WAKE_EN] && fall_edge)
                wake_seen_reg <= 1'b1;
            if (baud_ctrl_reg[rx_pkg::BIT_WAKE_EN] && wake_seen_reg
                && rise_edge)
            begin
                baud_ctrl_reg[rx_pkg::BIT_WAKE_EN] <= 1'b0;
                wake_seen_reg <= 1'b0;
            end
        end
    end
endmodule

// *** hdl/rx_pkg.sv ***
package rx_pkg;
    localparam logic [7:0] ADDR_RX_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RX_DATA = 8'h04;
    localparam logic [7:0] ADDR_TX_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BAUD_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h10;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h18;
    // receive_status_control fields
    localparam int BIT_SPORT_EN = 7;
    localparam int BIT_NINTH_EN = 6;
    localparam int BIT_CONT_EN = 4;
    localparam int BIT_ADDR_DET = 3;
    localparam int BIT_FRAME_ERR = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_NINTH_RX = 0;
    // transmit_status_control fields
    localparam int BIT_CLOCKED_MODE = 4;
    localparam int BIT_HIGH_BAUD = 2;
    // baud_control fields
    localparam int BIT_RX_IDLE = 6;
    localparam int BIT_WIDE_DIV = 3;
    localparam int BIT_WAKE_EN = 1;
    // irq control: complete flag, interrupt enable, sleep request
    localparam int BIT_CPL_FLAG = 0;
    localparam int BIT_IRQ_EN = 1;
    localparam int BIT_SLEEP = 2;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [7:0] RX_STATUS_WMASK = 8'hD8;
    localparam logic [7:0] TX_STATUS_WMASK = 8'h14;
    localparam logic [7:0] BAUD_CTRL_WMASK = 8'h0A;
    localparam logic [7:0] IRQ_CTRL_WMASK = 8'h06;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic frame_err;
    } frame_t;
endpackage

// *** tb/serial_rx_props.sv ***
`timescale 1ns/1ps
module serial_rx_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_input_pin,
    input wire logic receive_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved while waiting");
    a_rdata_byte: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_wr_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_bad_addr: assert property (
        s_wr_both ##0 (s_axi_awaddr > 8'h18)
        |-> ##2 s_axi_bresp == rx_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    // flag drops on a data read, irq follows a cycle behind
    a_irq_clears: assert property (
        s_rd_taken ##0 (s_axi_araddr == rx_pkg::ADDR_RX_DATA)
        |-> ##[1:4] !receive_irq)
        else $error("irq stays after data read");
    a_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !receive_irq)
        else $error("outputs active after reset");
endmodule
bind serial_rx serial_rx_props u_props (.*);

// *** tb/serial_node.sv ***
`timescale 1ns/1ps
module serial_node
#(
    parameter int BIT_CYCLES = 32
)
(
    input wire logic aclk,
    output logic line
);
    initial line = 1'b1;
    // hold a level for whole bit times, always launched after an edge
    task automatic level(input logic v, input int bits);
        begin
            line <= v;
            repeat (bits * BIT_CYCLES) @(posedge aclk);
        end
    endtask
    task automatic send(input logic [8:0] d, input int n, input logic stop);
        begin
            level(1'b0, 1);
            for (int i = 0; i < n; i++)
            begin
                level(d[i], 1);
            end
            level(stop, 1);
            level(1'b1, 1);
        end
    endtask
endmodule

// *** tb/serial_rx_tb.sv ***
`timescale 1ns/1ps
module serial_rx_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, serial_input_pin;
    logic receive_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors;
    int n_compared;
    serial_rx DUT (.*);
    // divisor 1: tick every 2 clocks, so 32 clocks a bit
    serial_node #(.BIT_CYCLES(32)) node (.aclk(aclk), .line(serial_input_pin));
    task automatic finish_test();
        begin
            if (num_errors == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_compared++;
            if (got !== exp)
            begin
                num_errors++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            check({30'h0, s_axi_bresp}, {30'h0, er});
            s_axi_bready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            @(posedge aclk);
            while (s_axi_arready !== 1'b1)
                @(posedge aclk);
            s_axi_arvalid <= 1'b0;
            // rready comes late so the held answer gets exercised
            @(posedge aclk);
            while (s_axi_rvalid !== 1'b1)
                @(posedge aclk);
            s_axi_rready <= 1'b1;
            @(posedge aclk);
            while (s_axi_rvalid !== 1'b1)
                @(posedge aclk);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        begin
            rd(a, d, r);
            check(d, {24'h000000, exp});
        end
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // roughly 12 frames of 352 to 384 clocks each, with ample slack
    initial
    begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        finish_test();
    end
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        num_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(8'h00, 8'h00);
        rc(8'h14, 8'h00);
        wr(8'h1C, 8'h00, 2'h2);
        rd(8'h1C, d, r);
        check({30'h0, r}, 32'h00000002);
        wr(8'h14, 8'h01, 2'h0);
        wr(8'h00, 8'h90, 2'h0);
        wr(8'h18, 8'h02, 2'h0);
        fork
            node.send(9'h0A5, 8, 1'b1);
            begin
                repeat (64) @(posedge aclk);
                rc(8'h0C, 8'h00);
            end
        join
        rc(8'h18, 8'h03);
        check({31'h0, receive_irq}, 32'h00000001);
        rc(8'h04, 8'hA5);
        rc(8'h18, 8'h02);
        wr(8'h00, 8'hD0, 2'h0);
        node.send(9'h13C, 9, 1'b1);
        rc(8'h00, 8'hD1);
        rc(8'h04, 8'h3C);
        wr(8'h00, 8'hD8, 2'h0);
        node.send(9'h077, 9, 1'b1);
        rc(8'h18, 8'h02);
        node.send(9'h155, 9, 1'b1);
        rc(8'h18, 8'h03);
        rc(8'h04, 8'h55);
        wr(8'h00, 8'hD0, 2'h0);
        node.send(9'h066, 9, 1'b1);
        rc(8'h18, 8'h03);
        rc(8'h04, 8'h66);
        wr(8'h00, 8'h90, 2'h0);
        node.send(9'h0F0, 8, 1'b0);
        rc(8'h00, 8'h94);
        rc(8'h04, 8'hF0);
        node.send(9'h011, 8, 1'b1);
        node.send(9'h022, 8, 1'b1);
        rc(8'h00, 8'h92);
        rc(8'h04, 8'h11);
        wr(8'h00, 8'h80, 2'h0);
        rc(8'h00, 8'h80);
        node.send(9'h033, 8, 1'b1);
        rc(8'h18, 8'h02);
        wr(8'h00, 8'h90, 2'h0);
        wr(8'h18, 8'h00, 2'h0);
        node.send(9'h044, 8, 1'b1);
        rc(8'h18, 8'h01);
        check({31'h0, receive_irq}, 32'h00000000);
        rc(8'h04, 8'h44);
        wr(8'h18, 8'h02, 2'h0);
        wr(8'h08, 8'h10, 2'h0);
        node.send(9'h05A, 8, 1'b1);
        rc(8'h18, 8'h02);
        wr(8'h08, 8'h00, 2'h0);
        wr(8'h18, 8'h06, 2'h0);
        node.send(9'h05A, 8, 1'b1);
        rc(8'h18, 8'h06);
        wr(8'h18, 8'h02, 2'h0);
        rc(8'h0C, 8'h40);
        wr(8'h0C, 8'h02, 2'h0);
        rc(8'h0C, 8'h42);
        node.level(1'b0, 12);
        rc(8'h18, 8'h03);
        rc(8'h0C, 8'h42);
        node.level(1'b1, 2);
        rc(8'h0C, 8'h40);
        rd(8'h04, d, r);
        rc(8'h18, 8'h02);
        finish_test();
    end
endmodule
